// [hdl/dcm_consts.vh]
/*
  constants for the doubleword coprocessor move / multiply execution unit:
  instruction field positions, opcode values, revision thresholds, timing.
  assumes it is included by its bare name from the hdl/ design files.
*/
`ifndef DCM_CONSTS_VH
`define DCM_CONSTS_VH

// instruction field positions
`define DCM_OP_HI        31
`define DCM_OP_LO        26
`define DCM_FMT_HI       25
`define DCM_FMT_LO       21
`define DCM_LOW11_HI     10
`define DCM_SA_HI        10
`define DCM_SA_LO        6
`define DCM_FN_HI        5

// opcode and format values
`define DCM_OP_COP0      6'h10
`define DCM_OP_COP1      6'h11
`define DCM_OP_COP2      6'h12
`define DCM_OP_SPECIAL   6'h00
`define DCM_FMT_DREAD    5'h01
`define DCM_FMT_DWRITE   5'h05
`define DCM_LOW11_ZERO   11'h000
`define DCM_FN_DMULS     6'h1c
`define DCM_FN_DMULU     6'h1d
`define DCM_FN_DWORD_ROTATE_RIGHT_FIXED     6'h3a
`define DCM_ROT_MARK     5'h01

// revision thresholds
`define DCM_REV_TRUNC    3'h2
`define DCM_REV_NOMUL    3'h6

// upper word filled on a narrow system-control read
`define DCM_UPPER_ZERO   32'h0000_0000

// multiplier latency in core cycles
`define DCM_MUL_CYCLES   4

`endif

// [hdl/dcm_mul.v]
/*
  dcm_mul: 64x64 multiplier giving a 128-bit product after a fixed latency.
  assumes start_i is a one-cycle pulse; a new start while busy is ignored.
*/
`timescale 1ns/1ps
`include "dcm_consts.vh"

module dcm_mul #(
  parameter LAT = `DCM_MUL_CYCLES
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         start_i,
  input  wire         signed_i,
  input  wire [63:0]  a_i,
  input  wire [63:0]  b_i,
  output reg          busy_o,
  output reg          done_o,
  output reg  [127:0] prod_o
);

  reg [7:0]   cnt_r;
  reg [127:0] acc_r;
  wire [127:0] ext_a;
  wire [127:0] ext_b;
  wire [127:0] full;

  // zero or sign extension to 128 bits, then a plain product of the low half
  assign ext_a = signed_i ? {{64{a_i[63]}}, a_i} : {64'h0000_0000_0000_0000, a_i};
  assign ext_b = signed_i ? {{64{b_i[63]}}, b_i} : {64'h0000_0000_0000_0000, b_i};
  assign full  = ext_a * ext_b; // low 128 bits are exact two's-complement product

  // product is formed at once and released after the latency count
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= 8'h00;
      acc_r  <= 128'h0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      prod_o <= 128'h0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        acc_r  <= full;
        cnt_r  <= LAT[7:0];
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_r <= 8'h01) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          prod_o <= acc_r;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end

endmodule

// [hdl/dcm_unit.v]
/*
  dcm_unit: execution of doubleword coprocessor moves, doubleword multiplies
  into the product registers, and the fixed doubleword rotate-right.
  assumes the integer pipeline presents one instruction with its operands
  on issue_i and accepts the answer on done_o; coprocessor register files
  answer reads in the same cycle through the *_rdata_i ports.
*/
`timescale 1ns/1ps
`include "dcm_consts.vh"

// Operation
// - narrow sysctl read zero-fills upper word from revision 2
// - sysctl write stores low word when narrow, from revision 2
// - decode float read, copy raw 64 bits
// - decode float write, store raw 64 bits
// - second cop read uses selector field
// - moves may raise unusable or reserved
// - signed multiply splits 128-bit product
// - unsigned multiply zero-extends then splits
// - multiplies never raise overflow
// - revision six or later reserves multiplies
// - product reads stall until result ready
// - rotate right all 64 bits by field
module dcm_unit #(
  parameter MUL_LAT = `DCM_MUL_CYCLES
) (
  input  wire        clk_i,
  input  wire        rst_i,
  // instruction issue
  input  wire        issue_i,
  input  wire [31:0] instr_i,
  input  wire [63:0] target_operand_i,
  input  wire [63:0] source_operand_i,
  input  wire [2:0]  arch_revision_field_i,
  input  wire        cop0_usable_i,
  input  wire        cop1_usable_i,
  input  wire        cop2_usable_i,
  input  wire        dword_ops_enable_i,
  // product register read request
  input  wire        prod_rd_i,
  input  wire        prod_sel_upper_i,
  // coprocessor register files
  input  wire [63:0] sysctl_rdata_i,
  input  wire        sysctl_narrow_i,
  input  wire [63:0] float_rdata_i,
  input  wire [63:0] second_rdata_i,
  // answer to the pipeline
  output reg         done_o,
  output reg         gpr_we_o,
  output reg  [4:0]  gpr_waddr_o,
  output reg  [63:0] gpr_wdata_o,
  output reg         exc_unusable_o,
  output reg         exc_reserved_o,
  output reg  [1:0]  exc_cop_o,
  output reg         stall_o,
  output reg         prod_valid_o,
  output reg  [63:0] prod_rdata_o,
  // coprocessor write ports and product registers
  output reg         sysctl_we_o,
  output reg  [7:0]  sysctl_addr_o,
  output reg  [63:0] sysctl_wdata_o,
  output reg         sysctl_wlow_o,
  output reg         float_we_o,
  output reg  [4:0]  float_addr_o,
  output reg  [63:0] float_wdata_o,
  output reg         second_we_o,
  output reg  [15:0] second_sel_o,
  output reg  [63:0] second_wdata_o,
  output reg  [63:0] upper_product_reg_o,
  output reg  [63:0] bottom_product_reg_o
);

  // instruction classes
  localparam C_NONE  = 4'h0;
  localparam C_RSYS  = 4'h1;
  localparam C_WSYS  = 4'h2;
  localparam C_RFLT  = 4'h3;
  localparam C_WFLT  = 4'h4;
  localparam C_RSEC  = 4'h5;
  localparam C_WSEC  = 4'h6;
  localparam C_MULS  = 4'h7;
  localparam C_MULU  = 4'h8;
  localparam C_ROT   = 4'h9;

  wire [5:0] op  = instr_i[`DCM_OP_HI:`DCM_OP_LO];
  wire [4:0] fmt = instr_i[`DCM_FMT_HI:`DCM_FMT_LO];
  wire [4:0] rt  = instr_i[20:16];
  wire [4:0] shift_amount_field = instr_i[`DCM_SA_HI:`DCM_SA_LO];
  wire [5:0] fn  = instr_i[`DCM_FN_HI:0];
  wire       low11_zero = (instr_i[`DCM_LOW11_HI:0] == `DCM_LOW11_ZERO);

  // classify one instruction word; used only for the issued instruction, the checker decodes on its own
  function [3:0] classify;
    input [31:0] w;
    reg   [5:0]  o;
    reg   [4:0]  f;
    begin
      o = w[`DCM_OP_HI:`DCM_OP_LO];
      f = w[`DCM_FMT_HI:`DCM_FMT_LO];
      classify = C_NONE;
      if (o == `DCM_OP_COP0 && f == `DCM_FMT_DREAD)
        classify = C_RSYS;
      else if (o == `DCM_OP_COP0 && f == `DCM_FMT_DWRITE)
        classify = C_WSYS;
      else if (o == `DCM_OP_COP1 && f == `DCM_FMT_DREAD
               && w[`DCM_LOW11_HI:0] == `DCM_LOW11_ZERO)
        classify = C_RFLT;
      else if (o == `DCM_OP_COP1 && f == `DCM_FMT_DWRITE
               && w[`DCM_LOW11_HI:0] == `DCM_LOW11_ZERO)
        classify = C_WFLT;
      else if (o == `DCM_OP_COP2 && f == `DCM_FMT_DREAD)
        classify = C_RSEC;
      else if (o == `DCM_OP_COP2 && f == `DCM_FMT_DWRITE)
        classify = C_WSEC;
      else if (o == `DCM_OP_SPECIAL && w[`DCM_SA_HI:`DCM_SA_LO] == 5'h00
               && w[`DCM_FN_HI:0] == `DCM_FN_DMULS)
        classify = C_MULS;
      else if (o == `DCM_OP_SPECIAL && w[`DCM_SA_HI:`DCM_SA_LO] == 5'h00
               && w[`DCM_FN_HI:0] == `DCM_FN_DMULU)
        classify = C_MULU;
      else if (o == `DCM_OP_SPECIAL && w[`DCM_FMT_HI:`DCM_FMT_LO] == `DCM_ROT_MARK
               && w[`DCM_FN_HI:0] == `DCM_FN_DWORD_ROTATE_RIGHT_FIXED)
        classify = C_ROT;
    end
  endfunction

  // rotate right by a 0..31 amount over all 64 bits
  function [63:0] rot_right;
    input [63:0] v;
    input [4:0]  s;
    reg   [127:0] d;
    begin
      d = {v, v} >> s;
      rot_right = d[63:0];
    end
  endfunction

  wire [3:0] cls = classify(instr_i);
  wire       is_mul = (cls == C_MULS) || (cls == C_MULU);
  wire       is_move = (cls >= C_RSYS) && (cls <= C_WSEC);
  wire       cop_ok = (op == `DCM_OP_COP0) ? cop0_usable_i :
                      (op == `DCM_OP_COP1) ? cop1_usable_i : cop2_usable_i;

  // exception decision: unusable beats reserved; reserved covers unknown words
  wire unusable = issue_i && is_move && !cop_ok;
  wire reserved = issue_i && !unusable &&
                  ((cls == C_NONE) || !dword_ops_enable_i ||
                   (is_mul && arch_revision_field_i >= `DCM_REV_NOMUL));
  wire exec_ok  = issue_i && !unusable && !reserved;

  wire          mul_busy;
  wire          mul_done;
  wire [127:0]  mul_prod;

  dcm_mul #(
    .LAT (MUL_LAT)
  ) u_mul (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (exec_ok && is_mul && !mul_busy),
    .signed_i (cls == C_MULS),
    .a_i      (source_operand_i),
    .b_i      (target_operand_i),
    .busy_o   (mul_busy),
    .done_o   (mul_done),
    .prod_o   (mul_prod)
  );

  reg pend_rd_r;

  // execution and write-back; a multiply issued while one runs is not started and gets no done_o
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_o         <= 1'b0;
      gpr_we_o       <= 1'b0;
      gpr_waddr_o    <= 5'h00;
      gpr_wdata_o    <= 64'h0000_0000_0000_0000;
      exc_unusable_o <= 1'b0;
      exc_reserved_o <= 1'b0;
      exc_cop_o      <= 2'h0;
      sysctl_we_o    <= 1'b0;
      sysctl_addr_o  <= 8'h00;
      sysctl_wdata_o <= 64'h0000_0000_0000_0000;
      sysctl_wlow_o  <= 1'b0;
      float_we_o     <= 1'b0;
      float_addr_o   <= 5'h00;
      float_wdata_o  <= 64'h0000_0000_0000_0000;
      second_we_o    <= 1'b0;
      second_sel_o   <= 16'h0000;
      second_wdata_o <= 64'h0000_0000_0000_0000;
    end else begin
      done_o         <= issue_i && !(is_mul && mul_busy && exec_ok);
      gpr_we_o       <= 1'b0;
      sysctl_we_o    <= 1'b0;
      float_we_o     <= 1'b0;
      second_we_o    <= 1'b0;
      exc_unusable_o <= unusable;
      exc_reserved_o <= reserved; // multiplies never flag overflow
      exc_cop_o      <= op[1:0];
      gpr_waddr_o    <= (cls == C_ROT) ? instr_i[15:11] : rt;
      if (exec_ok) begin
        case (cls)
          C_RSYS: begin
            gpr_we_o <= 1'b1;
            // narrow source below revision 2 is undefined; full word passes
            if (sysctl_narrow_i && arch_revision_field_i >= `DCM_REV_TRUNC)
              gpr_wdata_o <= {`DCM_UPPER_ZERO, sysctl_rdata_i[31:0]};
            else
              gpr_wdata_o <= sysctl_rdata_i;
          end
          C_WSYS: begin
            sysctl_we_o    <= 1'b1;
            // select sits in the low bits; software keeps it zero where unsupported,
            sysctl_addr_o  <= {instr_i[15:11], instr_i[2:0]};
            sysctl_wlow_o  <= sysctl_narrow_i &&
                              arch_revision_field_i >= `DCM_REV_TRUNC;
            sysctl_wdata_o <= (sysctl_narrow_i && arch_revision_field_i >= `DCM_REV_TRUNC)
                              ? {`DCM_UPPER_ZERO, target_operand_i[31:0]}
                              : target_operand_i;
          end
          C_RFLT: begin
            gpr_we_o    <= 1'b1;
            gpr_wdata_o <= float_rdata_i;
          end
          C_WFLT: begin
            float_we_o    <= 1'b1;
            float_addr_o  <= instr_i[15:11];
            float_wdata_o <= target_operand_i;
          end
          C_RSEC: begin
            gpr_we_o    <= 1'b1;
            gpr_wdata_o <= second_rdata_i;
          end
          C_WSEC: begin
            second_we_o    <= 1'b1;
            second_sel_o   <= instr_i[15:0];
            second_wdata_o <= target_operand_i;
          end
          C_ROT: begin
            gpr_we_o    <= 1'b1;
            gpr_wdata_o <= rot_right(target_operand_i, shift_amount_field);
          end
          default: begin
            gpr_we_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // product registers and interlocked reads
  always @(posedge clk_i) begin
    if (rst_i) begin
      upper_product_reg_o  <= 64'h0000_0000_0000_0000;
      bottom_product_reg_o <= 64'h0000_0000_0000_0000;
      pend_rd_r            <= 1'b0;
      stall_o              <= 1'b0;
      prod_valid_o         <= 1'b0;
      prod_rdata_o         <= 64'h0000_0000_0000_0000;
    end else begin
      prod_valid_o <= 1'b0;
      if (mul_done) begin
        bottom_product_reg_o <= mul_prod[63:0];
        upper_product_reg_o  <= mul_prod[127:64];
      end
      // a read while the multiply is in flight waits for the product
      if ((prod_rd_i || pend_rd_r) && (mul_busy || (exec_ok && is_mul))) begin
        pend_rd_r <= 1'b1;
        stall_o   <= 1'b1;
      end else if (prod_rd_i || pend_rd_r) begin
        pend_rd_r    <= 1'b0;
        stall_o      <= 1'b0;
        prod_valid_o <= 1'b1;
        if (mul_done)
          prod_rdata_o <= prod_sel_upper_i ? mul_prod[127:64] : mul_prod[63:0];
        else
          prod_rdata_o <= prod_sel_upper_i ? upper_product_reg_o : bottom_product_reg_o;
      end else begin
        // a multiply refused while busy is not a product read, so it never stalls
        stall_o <= 1'b0;
      end
    end
  end

endmodule

// [tb/dcm_cop_model.sv]
/*
  far-side model: coprocessor register files answering reads in the issue cycle.
  assumes the unit samples read data at the edge that takes issue_i.
*/
`timescale 1ns/1ps
module dcm_cop_model #(
  parameter logic [63:0] SYS_V = 64'h0000_0000_0000_0000,
  parameter logic [63:0] FLT_V = 64'h0000_0000_0000_0000,
  parameter logic [63:0] SEC_V = 64'h0000_0000_0000_0000
) (
  input  wire logic        issue_i,
  input  wire logic [31:0] instr_i,
  output logic      [63:0] sysctl_rdata_o,
  output logic             sysctl_narrow_o,
  output logic      [63:0] float_rdata_o,
  output logic      [63:0] second_rdata_o
);
  // data is inverted outside issue so a stale sample cannot pass for a fresh one
  always_comb begin
    sysctl_narrow_o = instr_i[11]; // odd register numbers are 32-bit
    sysctl_rdata_o  = issue_i ? SYS_V : ~SYS_V;
    float_rdata_o   = issue_i ? FLT_V : ~FLT_V;
    second_rdata_o  = (issue_i ? SEC_V : ~SEC_V) ^ {48'h0, instr_i[15:0]};
  end
endmodule

// [tb/dcm_unit_asserts.sv]
/*
  checker for dcm_unit: decode, move, exception and stall timing at the ports.
  assumes it is bound to every dcm_unit instance.
*/
`timescale 1ns/1ps
module dcm_unit_chk #(
  parameter int MUL_LAT = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        issue_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] target_operand_i,
  input wire logic [2:0]  arch_revision_field_i,
  input wire logic        cop0_usable_i,
  input wire logic        cop1_usable_i,
  input wire logic        cop2_usable_i,
  input wire logic        dword_ops_enable_i,
  input wire logic        sysctl_narrow_i,
  input wire logic [63:0] float_rdata_i,
  input wire logic        done_o,
  input wire logic        gpr_we_o,
  input wire logic [63:0] gpr_wdata_o,
  input wire logic        exc_unusable_o,
  input wire logic        exc_reserved_o,
  input wire logic        stall_o,
  input wire logic        prod_valid_o,
  input wire logic        sysctl_we_o,
  input wire logic        sysctl_wlow_o,
  input wire logic        float_we_o,
  input wire logic [63:0] float_wdata_o,
  input wire logic        second_we_o,
  input wire logic [15:0] second_sel_o
);
  localparam int WAIT_MAX = MUL_LAT + 2;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // decode of the issued word, only where issued and enabled; mul_go_s adds the revision limit for mul
  wire go   = issue_i & dword_ops_enable_i;
  wire rdf  = instr_i[25:21] == 5'h01;
  wire wrf  = instr_i[25:21] == 5'h05;
  wire nar  = sysctl_narrow_i & (arch_revision_field_i >= 3'h2);
  wire flt  = go & cop1_usable_i & (instr_i[31:26] == 6'h11) & (instr_i[10:0] == 11'h000);
  wire sys  = go & cop0_usable_i & (instr_i[31:26] == 6'h10) & nar;
  wire mul  = go & (instr_i[31:26] == 6'h00) & (instr_i[10:6] == 5'h00) &
              ((instr_i[5:0] == 6'h1c) | (instr_i[5:0] == 6'h1d));
  sequence mul_go_s;
    mul && arch_revision_field_i < 3'h6;
  endsequence
  done_has_cause_a: assert property (done_o |-> $past(issue_i))
    else $error("done without issue");
  exc_no_write_a: assert property ((exc_unusable_o || exc_reserved_o) |->
    !(gpr_we_o || sysctl_we_o || float_we_o || second_we_o))
    else $error("write beside exception");
  float_read_a: assert property (flt && rdf |=> gpr_we_o && gpr_wdata_o == $past(float_rdata_i))
    else $error("float read data wrong");
  float_write_a: assert property (flt && wrf |=> float_we_o &&
    float_wdata_o == $past(target_operand_i)) else $error("float write wrong");
  narrow_read_a: assert property (sys && rdf |=> gpr_wdata_o[63:32] == 32'h0000_0000)
    else $error("narrow read upper not zero");
  narrow_write_a: assert property (sys && wrf |=> sysctl_we_o && sysctl_wlow_o)
    else $error("narrow write not low");
  second_write_a: assert property (go && cop2_usable_i && instr_i[31:26] == 6'h12 && wrf
    |=> second_we_o && second_sel_o == $past(instr_i[15:0]))
    else $error("second write wrong");
  mul_no_exc_a: assert property (mul_go_s |=> !exc_reserved_o && !exc_unusable_o)
    else $error("multiply raised exception");
  late_mul_a: assert property (mul && arch_revision_field_i >= 3'h6 |=> exc_reserved_o)
    else $error("late multiply not reserved");
  stall_bound_a: assert property ($rose(stall_o) |-> stall_o until prod_valid_o)
    else $error("stall dropped early");
  stall_end_a: assert property ($rose(stall_o) |-> ##[1:WAIT_MAX] prod_valid_o)
    else $error("stall too long");
endmodule
bind dcm_unit dcm_unit_chk #(.MUL_LAT(MUL_LAT)) u_chk (.clk_i, .rst_i, .issue_i, .instr_i,
  .target_operand_i, .arch_revision_field_i, .cop0_usable_i, .cop1_usable_i, .cop2_usable_i,
  .dword_ops_enable_i, .sysctl_narrow_i, .float_rdata_i, .done_o, .gpr_we_o, .gpr_wdata_o,
  .exc_unusable_o, .exc_reserved_o, .stall_o, .prod_valid_o, .sysctl_we_o, .sysctl_wlow_o,
  .float_we_o, .float_wdata_o, .second_we_o, .second_sel_o);

// [tb/tb_top.sv]
/*
  testbench for dcm_unit: table of register reads and rotates, then writes, faults, multiplies.
  assumes the coprocessor model answers reads in the issue cycle.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  localparam logic [63:0] SYS_V = 64'hfedc_ba98_7654_3210;
  localparam logic [63:0] FLT_V = 64'h0f1e_2d3c_4b5a_6978;
  localparam logic [63:0] SEC_V = 64'h8877_6655_4433_2211;
  localparam logic [63:0] T = 64'h8000_0000_0000_0003;
  typedef struct packed {logic [31:0] ins; logic [4:0] wa; logic [63:0] exp;} dcm_row_t;
  logic clk_i = 0, rst_i = 1, issue_i = 0, cop0_usable_i = 1, cop1_usable_i = 1;
  logic cop2_usable_i = 1, dword_ops_enable_i = 1, prod_rd_i = 0, prod_sel_upper_i = 0, stalled;
  logic [31:0] instr_i = 0;
  logic [63:0] target_operand_i = 0, source_operand_i = 0;
  logic [2:0] arch_revision_field_i = 3'h2;
  wire [63:0] sysctl_rdata_i, float_rdata_i, second_rdata_i, gpr_wdata_o, prod_rdata_o;
  wire [63:0] sysctl_wdata_o, float_wdata_o, second_wdata_o, upper_product_reg_o;
  wire [63:0] bottom_product_reg_o;
  wire sysctl_narrow_i, done_o, gpr_we_o, exc_unusable_o, exc_reserved_o, stall_o;
  wire prod_valid_o, sysctl_we_o, sysctl_wlow_o, float_we_o, second_we_o;
  wire [4:0] gpr_waddr_o, float_addr_o;
  wire [1:0] exc_cop_o;
  wire [7:0] sysctl_addr_o;
  wire [15:0] second_sel_o;
  int fails = 0, cmp_count = 0;
  dcm_row_t rows [6];
  always #20 clk_i = ~clk_i;
  dcm_cop_model #(.SYS_V(SYS_V), .FLT_V(FLT_V), .SEC_V(SEC_V)) u_dcm_cop_model (.issue_i,
    .instr_i, .sysctl_rdata_o(sysctl_rdata_i), .sysctl_narrow_o(sysctl_narrow_i),
    .float_rdata_o(float_rdata_i), .second_rdata_o(second_rdata_i));
  dcm_unit #(.MUL_LAT(4)) u_dcm_unit (.clk_i, .rst_i, .issue_i, .instr_i, .target_operand_i,
    .source_operand_i, .arch_revision_field_i, .cop0_usable_i, .cop1_usable_i, .cop2_usable_i,
    .dword_ops_enable_i, .prod_rd_i, .prod_sel_upper_i, .sysctl_rdata_i, .sysctl_narrow_i,
    .float_rdata_i, .second_rdata_i, .done_o, .gpr_we_o, .gpr_waddr_o, .gpr_wdata_o,
    .exc_unusable_o, .exc_reserved_o, .exc_cop_o, .stall_o, .prod_valid_o, .prod_rdata_o,
    .sysctl_we_o, .sysctl_addr_o, .sysctl_wdata_o, .sysctl_wlow_o, .float_we_o, .float_addr_o,
    .float_wdata_o, .second_we_o, .second_sel_o, .second_wdata_o, .upper_product_reg_o,
    .bottom_product_reg_o);
  task automatic final_report();
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one issue pulse; returns once the answer cycle has settled
  task automatic issue(input logic [31:0] ins, input logic [2:0] r);
    @(posedge clk_i);
    issue_i <= 1'b1;
    instr_i <= ins;
    arch_revision_field_i <= r;
    @(posedge clk_i);
    issue_i <= 1'b0;
    #1;
  endtask
  // product read; the wait is bounded so a missing answer cannot hang the run
  task automatic rd_prod(input logic up);
    int n;
    @(posedge clk_i);
    prod_rd_i <= 1'b1;
    prod_sel_upper_i <= up;
    @(posedge clk_i);
    prod_rd_i <= 1'b0;
    n = 0;
    stalled = 0;
    #1;
    while (prod_valid_o !== 1'b1 && n < 20) begin
      stalled = stalled | stall_o;
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n == 20) begin
      fails++;
      final_report();
    end
  endtask
  initial begin
    rows = '{'{32'h4025_1000, 5'd5, SYS_V}, '{32'h4025_1800, 5'd5, {32'h0, SYS_V[31:0]}},
      '{32'h4427_4800, 5'd7, FLT_V}, '{32'h4828_1234, 5'd8, SEC_V ^ 64'h1234},
      '{32'h0024_303a, 5'd6, T}, '{32'h0024_37fa, 5'd6, {T[30:0], T[63:31]}}};
    target_operand_i = T;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("reset done", 1'b0, done_o)
    `CHK("reset upper", 64'h0, upper_product_reg_o)
    foreach (rows[i]) begin
      issue(rows[i].ins, 3'h2);
      `CHK("row we", 1'b1, gpr_we_o)
      `CHK("row addr", rows[i].wa, gpr_waddr_o)
      `CHK("row data", rows[i].exp, gpr_wdata_o)
    end
    issue(32'h40a5_1000, 3'h2);
    `CHK("sys wide", {1'b1, 8'h10, T, 1'b0}, {sysctl_we_o, sysctl_addr_o,
      sysctl_wdata_o, sysctl_wlow_o})
    issue(32'h40a5_1800, 3'h2);
    `CHK("sys narrow", {1'b1, T[31:0]}, {sysctl_wlow_o, sysctl_wdata_o[31:0]})
    issue(32'h44a7_4800, 3'h2);
    `CHK("flt write", {1'b1, 5'd9, T}, {float_we_o, float_addr_o, float_wdata_o})
    issue(32'h48a8_1234, 3'h2);
    `CHK("sec write", {1'b1, 16'h1234, T}, {second_we_o, second_sel_o,
      second_wdata_o})
    cop1_usable_i <= 1'b0;
    issue(32'h4427_4800, 3'h2);
    `CHK("unusable", 4'b1001, {exc_unusable_o, gpr_we_o, exc_cop_o})
    cop1_usable_i <= 1'b1;
    issue(32'h4427_4801, 3'h2);
    `CHK("reserved", 2'b10, {exc_reserved_o, gpr_we_o})
    source_operand_i <= 64'hffff_ffff_ffff_fffd;
    target_operand_i <= 64'h5;
    issue(32'h0022_001c, 3'h2);
    `CHK("mul ok", 2'b10, {done_o, exc_reserved_o})
    rd_prod(1'b1);
    `CHK("mul stall", 1'b1, stalled)
    `CHK("mul hi", 64'hffff_ffff_ffff_ffff, prod_rdata_o)
    `CHK("mul lo", 64'hffff_ffff_ffff_fff1, bottom_product_reg_o)
    source_operand_i <= 64'hffff_ffff_ffff_ffff;
    target_operand_i <= 64'h2;
    issue(32'h0022_001d, 3'h2);
    rd_prod(1'b0);
    `CHK("mulu lo", 64'hffff_ffff_ffff_fffe, prod_rdata_o)
    `CHK("mulu hi", 64'h1, upper_product_reg_o)
    issue(32'h0022_001c, 3'h6);
    `CHK("late mul", 1'b1, exc_reserved_o)
    repeat (6) @(posedge clk_i);
    #1;
    `CHK("late keep", 64'h1, upper_product_reg_o)
    final_report();
  end
endmodule
